// *** logic/pfe_pkg.sv ***
/*
 * Shared constants, types and decode helpers for the peripheral interrupt flag and enable bank.
 * Assumes a single 250 MHz clock, synchronous active-low reset and a 32-bit AXI4-Lite register bus.
 */
// Contract
// - Oscillator fail sets flags2 bit 7, software clears.
// - Comparator change sets flags2 bit 6, software clears.
// - Bus collision sets flags2 bit 3, software clears.
// - Low-voltage event sets flags2 bit 2, software clears.
// - Timer three overflow sets flags2 bit 1.
// - Display frame sets flags3 bit 6 in type-B non-static.
// - Flags3 bit 5 read-only, mirrors receive buffer full.
// - Flags3 bit 4 read-only, mirrors transmit buffer empty.
// - Charge time unit event sets flags3 bit 3.
// - Capture event sets capcmp flag bit 2 or 1.
// - Compare match sets capcmp flag, software clears.
// - Pulse-width mode never sets capcmp flags.
// - Calendar event sets flags3 bit 0, software clears.
// - Three enable registers gate flags bit by bit.
// - Without priority levels, global enable also required.
// - Enables1 bits 6,5,4,3,1,0; bits 7,2 read zero.
// - Enables2 bits 7,6,3,2,1; others read zero.
// - Enables3 bits 6..0 gate same flags3 positions.
// - Bit 7 of enables3 and flags3 reads zero.
// - Flags set regardless of any enable bit.
// - Priority-enable selects two levels or single level.
package pfe_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] OFS_FLAGS_2   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS_3   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ENABLES_1 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ENABLES_2 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ENABLES_3 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;

	// Implemented-bit masks and reset values.
	localparam logic [REG_W-1:0] MASK_FLAGS_2    = 8'hCE;
	localparam logic [REG_W-1:0] MASK_FLAGS_3    = 8'h7F;
	localparam logic [REG_W-1:0] MASK_FLAGS_3_SW = 8'h4F;
	localparam logic [REG_W-1:0] MASK_ENABLES_1  = 8'h7B;
	localparam logic [REG_W-1:0] MASK_ENABLES_2  = 8'hCE;
	localparam logic [REG_W-1:0] MASK_ENABLES_3  = 8'h7F;
	localparam logic [REG_W-1:0] RESET_VALUE     = 8'h00;

	// Flag bit positions.
	localparam int unsigned BIT_OSC_FAIL      = 7;
	localparam int unsigned BIT_COMPARATOR    = 6;
	localparam int unsigned BIT_BUS_COLLISION = 3;
	localparam int unsigned BIT_LOW_VOLTAGE   = 2;
	localparam int unsigned BIT_TIMER3        = 1;
	localparam int unsigned BIT_DISPLAY       = 6;
	localparam int unsigned BIT_SERIAL2_RX    = 5;
	localparam int unsigned BIT_SERIAL2_TX    = 4;
	localparam int unsigned BIT_CHARGE_TIME   = 3;
	localparam int unsigned BIT_CAPCMP2       = 2;
	localparam int unsigned BIT_CAPCMP1       = 1;
	localparam int unsigned BIT_CALENDAR      = 0;

	// Status register bit positions.
	localparam int unsigned BIT_ST_REQUEST  = 0;
	localparam int unsigned BIT_ST_GLOBAL   = 1;
	localparam int unsigned BIT_ST_PRIORITY = 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PFE_SEL_FLAGS_2   = 3'b000,
		PFE_SEL_FLAGS_3   = 3'b001,
		PFE_SEL_ENABLES_1 = 3'b010,
		PFE_SEL_ENABLES_2 = 3'b011,
		PFE_SEL_ENABLES_3 = 3'b100,
		PFE_SEL_STATUS    = 3'b101,
		PFE_SEL_NONE      = 3'b111
	} pfe_sel_t;

	typedef enum logic [1:0] {
		PFE_CC_OFF     = 2'b00,
		PFE_CC_CAPTURE = 2'b01,
		PFE_CC_COMPARE = 2'b10,
		PFE_CC_PWM     = 2'b11
	} pfe_capcmp_mode_t;

	// One-cycle event pulses from the peripherals.
	typedef struct packed {
		logic osc_fail;
		logic comparator;
		logic bus_collision;
		logic low_voltage;
		logic timer3_overflow;
		logic display_frame;
		logic charge_time;
		logic capcmp2;
		logic capcmp1;
		logic calendar;
	} pfe_events_t;

	// A register write handed from the bus slave to the bank.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [3:0]        strb;
	} pfe_wr_t;

	function automatic pfe_sel_t pfe_decode(input logic [ADDR_W-1:0] addr);
		case (addr)
			OFS_FLAGS_2:   pfe_decode = PFE_SEL_FLAGS_2;
			OFS_FLAGS_3:   pfe_decode = PFE_SEL_FLAGS_3;
			OFS_ENABLES_1: pfe_decode = PFE_SEL_ENABLES_1;
			OFS_ENABLES_2: pfe_decode = PFE_SEL_ENABLES_2;
			OFS_ENABLES_3: pfe_decode = PFE_SEL_ENABLES_3;
			OFS_STATUS:    pfe_decode = PFE_SEL_STATUS;
			default:       pfe_decode = PFE_SEL_NONE;
		endcase
	endfunction : pfe_decode

endpackage : pfe_pkg

// *** logic/pfe_axil_slave.sv ***
/*
 * AXI4-Lite slave front end: takes write address and data in either order, one read and one write at a time.
 * Assumes the bank decodes addresses combinationally and answers rd_data and error flags in the same cycle.
 */
`timescale 1ns/1ps
module pfe_axil_slave (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// Write channels
	input  wire logic [pfe_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [pfe_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// Read channels
	input  wire logic [pfe_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [pfe_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Bank side
	output logic                               wr_en,
	output pfe_pkg::pfe_wr_t                   wr,
	input  wire logic                          wr_err,
	output logic [pfe_pkg::ADDR_W-1:0]         rd_addr,
	input  wire logic [pfe_pkg::DATA_W-1:0]    rd_data,
	input  wire logic                          rd_err
);

	logic                        aw_held;
	logic                        w_held;
	logic                        rd_pend;
	logic [pfe_pkg::ADDR_W-1:0]  wr_addr;
	logic [pfe_pkg::DATA_W-1:0]  wr_data;
	logic [3:0]                  wr_strb;

	// The two halves are captured by separate processes, so the struct is assembled here with one driver.
	assign wr = '{addr: wr_addr, data: wr_data, strb: wr_strb};

	// The write commits once both halves are held; ready stays low until the response is taken.
	assign wr_en = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b1;
			wr_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held       <= 1'b1;
			s_axi_awready <= 1'b0;
			wr_addr       <= s_axi_awaddr;
		end else if (wr_en) begin
			aw_held       <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b1;
			wr_data      <= '0;
			wr_strb      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held       <= 1'b1;
			s_axi_wready <= 1'b0;
			wr_data      <= s_axi_wdata;
			wr_strb      <= s_axi_wstrb;
		end else if (wr_en) begin
			w_held       <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pfe_pkg::RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_err ? pfe_pkg::RESP_SLVERR : pfe_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend       <= 1'b0;
			s_axi_arready <= 1'b1;
			rd_addr       <= '0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= pfe_pkg::RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				rd_pend       <= 1'b1;
				s_axi_arready <= 1'b0;
				rd_addr       <= s_axi_araddr;
			end else if (rd_pend) begin
				rd_pend      <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_err ? pfe_pkg::RESP_SLVERR : pfe_pkg::RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : pfe_axil_slave

// *** logic/pfe_bank.sv ***
/*
 * Peripheral interrupt flag registers 2 and 3 and enable registers 1 to 3, with the peripheral request output.
 * Assumes event pulses and buffer levels come from logic on aclk, and that flag register 1, the global
 * peripheral enable and the priority-enable bit are held elsewhere in the controller.
 */
`timescale 1ns/1ps
module pfe_bank (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite write address
	input  wire logic [pfe_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [pfe_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [pfe_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// AXI4-Lite read data
	output logic [pfe_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Peripheral events and levels
	input  pfe_pkg::pfe_events_t               events,
	input  wire logic                          serial2_rx_full,
	input  wire logic                          serial2_tx_empty,
	// Peripheral modes
	input  pfe_pkg::pfe_capcmp_mode_t          capcmp1_mode,
	input  pfe_pkg::pfe_capcmp_mode_t          capcmp2_mode,
	input  wire logic                          display_type_b,
	input  wire logic                          display_nonstatic,
	// Rest of the interrupt controller
	input  wire logic [pfe_pkg::REG_W-1:0]     periph_flags_1,
	input  wire logic                          peripheral_global_enable,
	input  wire logic                          priority_levels_enable,
	// Requests toward the core
	output logic [pfe_pkg::REG_W-1:0]          active_1,
	output logic [pfe_pkg::REG_W-1:0]          active_2,
	output logic [pfe_pkg::REG_W-1:0]          active_3,
	output logic                               periph_request
);

	logic                              wr_en;
	pfe_pkg::pfe_wr_t                  wr;
	logic                              wr_err;
	logic [pfe_pkg::ADDR_W-1:0]        rd_addr;
	logic [pfe_pkg::DATA_W-1:0]        rd_data;
	logic                              rd_err;

	logic [pfe_pkg::REG_W-1:0]         periph_flags_2;
	logic [pfe_pkg::REG_W-1:0]         periph_flags_3;
	logic [pfe_pkg::REG_W-1:0]         periph_enables_1;
	logic [pfe_pkg::REG_W-1:0]         periph_enables_2;
	logic [pfe_pkg::REG_W-1:0]         periph_enables_3;

	logic [pfe_pkg::REG_W-1:0]         set_2;
	logic [pfe_pkg::REG_W-1:0]         set_3;
	logic [pfe_pkg::REG_W-1:0]         next_periph_flags_2;
	logic [pfe_pkg::REG_W-1:0]         next_periph_flags_3;
	logic [pfe_pkg::REG_W-1:0]         wr_byte;
	logic                              wr_lane0;
	pfe_pkg::pfe_sel_t                 wr_sel;
	pfe_pkg::pfe_sel_t                 rd_sel;
	logic                              display_valid;
	logic                              capcmp1_counts;
	logic                              capcmp2_counts;
	logic [pfe_pkg::REG_W-1:0]         next_active_1;
	logic [pfe_pkg::REG_W-1:0]         next_active_2;
	logic [pfe_pkg::REG_W-1:0]         next_active_3;
	logic                              any_active;
	logic                              next_periph_request;
	logic [pfe_pkg::REG_W-1:0]         status;

	pfe_axil_slave u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr            (wr),
		.wr_err        (wr_err),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	// Write decode. Every register is eight bits wide, so only byte lane zero carries data.
	assign wr_sel   = pfe_pkg::pfe_decode(wr.addr);
	assign wr_err   = (wr_sel == pfe_pkg::PFE_SEL_NONE);
	assign wr_byte  = wr.data[pfe_pkg::REG_W-1:0];
	assign wr_lane0 = wr_en && wr.strb[0];

	// Event qualification by peripheral mode.
	assign display_valid  = display_type_b && display_nonstatic;
	assign capcmp1_counts = (capcmp1_mode == pfe_pkg::PFE_CC_CAPTURE)
		|| (capcmp1_mode == pfe_pkg::PFE_CC_COMPARE);
	assign capcmp2_counts = (capcmp2_mode == pfe_pkg::PFE_CC_CAPTURE)
		|| (capcmp2_mode == pfe_pkg::PFE_CC_COMPARE);

	// Hardware set terms for flag register 2. No enable bit takes part here.
	always_comb begin
		set_2                                  = '0;
		set_2[pfe_pkg::BIT_OSC_FAIL]           = events.osc_fail;
		set_2[pfe_pkg::BIT_COMPARATOR]         = events.comparator;
		set_2[pfe_pkg::BIT_BUS_COLLISION]      = events.bus_collision;
		set_2[pfe_pkg::BIT_LOW_VOLTAGE]        = events.low_voltage;
		set_2[pfe_pkg::BIT_TIMER3]             = events.timer3_overflow;
	end

	// Hardware set terms for the software-cleared bits of flag register 3.
	always_comb begin
		set_3                                  = '0;
		set_3[pfe_pkg::BIT_DISPLAY]            = events.display_frame && display_valid;
		set_3[pfe_pkg::BIT_CHARGE_TIME]        = events.charge_time;
		set_3[pfe_pkg::BIT_CAPCMP2]            = events.capcmp2 && capcmp2_counts;
		set_3[pfe_pkg::BIT_CAPCMP1]            = events.capcmp1 && capcmp1_counts;
		set_3[pfe_pkg::BIT_CALENDAR]           = events.calendar;
	end

	// A hardware set in the same cycle as a software write of zero wins, so no event is lost.
	always_comb begin
		next_periph_flags_2 = periph_flags_2 | set_2;
		if (wr_lane0 && (wr_sel == pfe_pkg::PFE_SEL_FLAGS_2)) begin
			next_periph_flags_2 = wr_byte | set_2;
		end
		next_periph_flags_2 = next_periph_flags_2 & pfe_pkg::MASK_FLAGS_2;
	end

	// The two serial buffer bits are plain mirrors; the buffer itself clears its level on access.
	always_comb begin
		next_periph_flags_3 = periph_flags_3 | set_3;
		if (wr_lane0 && (wr_sel == pfe_pkg::PFE_SEL_FLAGS_3)) begin
			next_periph_flags_3 = wr_byte | set_3;
		end
		next_periph_flags_3                          = next_periph_flags_3 & pfe_pkg::MASK_FLAGS_3_SW;
		next_periph_flags_3[pfe_pkg::BIT_SERIAL2_RX] = serial2_rx_full;
		next_periph_flags_3[pfe_pkg::BIT_SERIAL2_TX] = serial2_tx_empty;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_flags_2 <= pfe_pkg::RESET_VALUE;
		end else begin
			periph_flags_2 <= next_periph_flags_2;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_flags_3 <= pfe_pkg::RESET_VALUE;
		end else begin
			periph_flags_3 <= next_periph_flags_3;
		end
	end

	// Enable registers; unimplemented bits are masked off so they always read zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_enables_1 <= pfe_pkg::RESET_VALUE;
		end else if (wr_lane0 && (wr_sel == pfe_pkg::PFE_SEL_ENABLES_1)) begin
			periph_enables_1 <= wr_byte & pfe_pkg::MASK_ENABLES_1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_enables_2 <= pfe_pkg::RESET_VALUE;
		end else if (wr_lane0 && (wr_sel == pfe_pkg::PFE_SEL_ENABLES_2)) begin
			periph_enables_2 <= wr_byte & pfe_pkg::MASK_ENABLES_2;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_enables_3 <= pfe_pkg::RESET_VALUE;
		end else if (wr_lane0 && (wr_sel == pfe_pkg::PFE_SEL_ENABLES_3)) begin
			periph_enables_3 <= wr_byte & pfe_pkg::MASK_ENABLES_3;
		end
	end

	// Per-bit gating of each flag by its enable, for all three flag registers.
	// The display enable only has effect while its flag can be set, so it needs no extra term.
	genvar g;
	generate
		for (g = 0; g < pfe_pkg::REG_W; g++) begin : g_gate
			assign next_active_1[g] = periph_flags_1[g] && periph_enables_1[g];
			assign next_active_2[g] = periph_flags_2[g] && periph_enables_2[g];
			assign next_active_3[g] = periph_flags_3[g] && periph_enables_3[g];
		end
	endgenerate

	assign any_active = |{next_active_1, next_active_2, next_active_3};

	// In single-level mode the global peripheral enable must also be set; with two levels the
	// priority logic downstream does its own gating, so the raw combination passes through.
	assign next_periph_request = any_active
		&& (priority_levels_enable || peripheral_global_enable);

	// Outputs are registered, which costs one cycle of request latency but keeps them glitch free.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_1       <= pfe_pkg::RESET_VALUE;
			active_2       <= pfe_pkg::RESET_VALUE;
			active_3       <= pfe_pkg::RESET_VALUE;
			periph_request <= 1'b0;
		end else begin
			active_1       <= next_active_1;
			active_2       <= next_active_2;
			active_3       <= next_active_3;
			periph_request <= next_periph_request;
		end
	end

	// Read-only status view of the request path and its mode inputs.
	always_comb begin
		status                           = '0;
		status[pfe_pkg::BIT_ST_REQUEST]  = periph_request;
		status[pfe_pkg::BIT_ST_GLOBAL]   = peripheral_global_enable;
		status[pfe_pkg::BIT_ST_PRIORITY] = priority_levels_enable;
	end

	// Read mux; unmapped addresses return zero with an error response.
	assign rd_sel = pfe_pkg::pfe_decode(rd_addr);

	always_comb begin
		rd_data = '0;
		rd_err  = 1'b0;
		case (rd_sel)
			pfe_pkg::PFE_SEL_FLAGS_2:   rd_data[pfe_pkg::REG_W-1:0] = periph_flags_2;
			pfe_pkg::PFE_SEL_FLAGS_3:   rd_data[pfe_pkg::REG_W-1:0] = periph_flags_3;
			pfe_pkg::PFE_SEL_ENABLES_1: rd_data[pfe_pkg::REG_W-1:0] = periph_enables_1;
			pfe_pkg::PFE_SEL_ENABLES_2: rd_data[pfe_pkg::REG_W-1:0] = periph_enables_2;
			pfe_pkg::PFE_SEL_ENABLES_3: rd_data[pfe_pkg::REG_W-1:0] = periph_enables_3;
			pfe_pkg::PFE_SEL_STATUS:    rd_data[pfe_pkg::REG_W-1:0] = status;
			default:                    rd_err = 1'b1;
		endcase
	end

endmodule : pfe_bank

// *** verif/pfe_bank_sva.sv ***
/*
 * Checker for the peripheral flag and enable bank: relations between the serial levels, the gates and the requests.
 * Assumes one clock, aclk, and the synchronous active-low reset aresetn of the bank.
 */
`timescale 1ns/1ps
module pfe_bank_sva (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Levels and gates
	input wire logic       serial2_rx_full,
	input wire logic       serial2_tx_empty,
	input wire logic       peripheral_global_enable,
	input wire logic       priority_levels_enable,
	// Requests
	input wire logic [7:0] active_1,
	input wire logic [7:0] active_2,
	input wire logic [7:0] active_3,
	input wire logic       periph_request
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rx_clear; !serial2_rx_full |-> ##2 !active_3[5]; endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("receive flag outlives an empty buffer");
	property p_tx_clear; !serial2_tx_empty |-> ##2 !active_3[4]; endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("transmit flag outlives a full buffer");
	property p_gate; $past(!priority_levels_enable && !peripheral_global_enable) |-> !periph_request; endproperty
	a_gate: assert property (p_gate) else $error("request without the global gate");
	property p_holes1; (active_1 & 8'h84) == 8'h00; endproperty
	a_holes1: assert property (p_holes1) else $error("unimplemented request bit in group one");
	property p_holes2; (active_2 & 8'h31) == 8'h00; endproperty
	a_holes2: assert property (p_holes2) else $error("unimplemented request bit in group two");
	property p_holes3; !active_3[7]; endproperty
	a_holes3: assert property (p_holes3) else $error("unimplemented request bit in group three");
	property p_prio; $past(priority_levels_enable) && (|{active_1, active_2, active_3}) |-> periph_request; endproperty
	a_prio: assert property (p_prio) else $error("priority mode blocked a request");
	property p_or; !(|{active_1, active_2, active_3}) |-> !periph_request; endproperty
	a_or: assert property (p_or) else $error("request with no active source");
endmodule : pfe_bank_sva

bind pfe_bank pfe_bank_sva u_pfe_bank_sva (.aclk, .aresetn, .serial2_rx_full, .serial2_tx_empty,
	.peripheral_global_enable, .priority_levels_enable, .active_1, .active_2, .active_3, .periph_request);

// *** verif/pfe_periph_model.sv ***
/*
 * Peripheral event sources for the flag bank: one-cycle event pulses and the serial buffer levels.
 * Assumes the bank samples all of them on the rising edge of aclk and calls arrive just after an edge.
 */
`timescale 1ns/1ps
module pfe_periph_model (
	// Clock
	input  wire logic            aclk,
	// Toward the bank
	output pfe_pkg::pfe_events_t events,
	output logic                 serial2_rx_full,
	output logic                 serial2_tx_empty
);
	initial begin
		events = 10'h000;
		serial2_rx_full = 1'h0;
		serial2_tx_empty = 1'h0;
	end
	// A held level would keep setting the flag, so every event is exactly one cycle wide.
	task automatic fire(input int unsigned i);
		events[i] <= 1'h1;
		@(posedge aclk);
		events <= 10'h000;
	endtask : fire
	task automatic levels(input logic rx, input logic tx);
		serial2_rx_full <= rx;
		serial2_tx_empty <= tx;
	endtask : levels
endmodule : pfe_periph_model

// *** verif/test_pfe_bank.sv ***
/*
 * Self-checking bench for pfe_bank: register access over AXI4-Lite, events, serial levels and the request output.
 * Assumes the event model and the bound checker; every call is made just after a rising edge of aclk.
 */
`timescale 1ns/1ps
module test_pfe_bank;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, periph_flags_1 = 8'h00, active_1, active_2, active_3;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        peripheral_global_enable = 1'h0, priority_levels_enable = 1'h0, periph_request;
	logic        display_type_b = 1'h1, display_nonstatic = 1'h1, serial2_rx_full, serial2_tx_empty;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	pfe_pkg::pfe_capcmp_mode_t capcmp1_mode = pfe_pkg::PFE_CC_CAPTURE, capcmp2_mode = pfe_pkg::PFE_CC_CAPTURE;
	pfe_pkg::pfe_events_t      events;
	int          n_errors = 0, num_checks = 0;
	int unsigned eb[10] = '{0, 1, 2, 3, 6, 1, 2, 3, 6, 7};
	logic [7:0]  eofs[3] = '{8'h08, 8'h0C, 8'h10}, emsk[3] = '{8'h7B, 8'hCE, 8'h7F};

	always #2 aclk = ~aclk;
	pfe_bank u_pfe_bank (.*);
	pfe_periph_model u_pfe_periph_model (.aclk, .events, .serial2_rx_full, .serial2_tx_empty);

	task automatic stop_test;
		if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("write response", {30'h0, s_axi_bresp}, {30'h0, er});
		// One idle edge, so a following call never lowers and raises a ready in one step.
		@(posedge aclk);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		chk(what, d, exp);
		chk("read response", {30'h0, r}, {30'h0, er});
		@(posedge aclk);
	endtask : rchk
	// Outputs are read at the edge, before its own updates land, so stimulus stays on the edge.
	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask : settle

	initial begin
		repeat (5000) @(posedge aclk);
		n_errors++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0, 2'h0, "reset value");
		rchk(8'h18, 32'h0, 2'h2, "unmapped read");
		wr(8'h18, 32'hFF, 2'h2);
		for (int i = 0; i < 3; i++) begin
			wr(eofs[i], 32'hFFFFFFFF, 2'h0);
			rchk(eofs[i], {24'h0, emsk[i]}, 2'h0, "enable mask");
			wr(eofs[i], 32'h0, 2'h0);
		end
		wr(8'h00, 32'hFFFFFFFF, 2'h0);
		rchk(8'h00, 32'hCE, 2'h0, "flag two mask");
		wr(8'h04, 32'hFFFFFFFF, 2'h0);
		rchk(8'h04, 32'h4F, 2'h0, "flag three mask");
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		for (int i = 0; i < 10; i++) begin
			u_pfe_periph_model.fire(i);
			rchk(i < 5 ? 8'h04 : 8'h00, 32'h1 << eb[i], 2'h0, "event flag");
			wr(i < 5 ? 8'h04 : 8'h00, 32'h0, 2'h0);
			rchk(i < 5 ? 8'h04 : 8'h00, 32'h0, 2'h0, "flag cleared");
		end
		for (int m = 0; m < 4; m++) begin
			capcmp1_mode <= pfe_pkg::pfe_capcmp_mode_t'(m);
			u_pfe_periph_model.fire(1);
			rchk(8'h04, (m == 1 || m == 2) ? 32'h2 : 32'h0, 2'h0, "capture compare flag");
			wr(8'h04, 32'h0, 2'h0);
		end
		display_nonstatic <= 1'h0;
		u_pfe_periph_model.fire(4);
		rchk(8'h04, 32'h0, 2'h0, "static display flag");
		wr(8'h10, 32'h30, 2'h0);
		u_pfe_periph_model.levels(1'h1, 1'h1);
		settle();
		wr(8'h04, 32'h0, 2'h0);
		rchk(8'h04, 32'h30, 2'h0, "serial flags");
		chk("active three", {24'h0, active_3}, 32'h30);
		u_pfe_periph_model.levels(1'h0, 1'h0);
		settle();
		rchk(8'h04, 32'h0, 2'h0, "serial flags gone");
		chk("active three gone", {24'h0, active_3}, 32'h0);
		wr(8'h0C, 32'h40, 2'h0);
		u_pfe_periph_model.fire(8);
		settle();
		chk("active two", {24'h0, active_2}, 32'h40);
		chk("request ungated", {31'h0, periph_request}, 32'h0);
		peripheral_global_enable <= 1'h1;
		settle();
		chk("request global", {31'h0, periph_request}, 32'h1);
		rchk(8'h14, 32'h3, 2'h0, "status global");
		peripheral_global_enable <= 1'h0;
		priority_levels_enable <= 1'h1;
		settle();
		chk("request priority", {31'h0, periph_request}, 32'h1);
		wr(8'h00, 32'h0, 2'h0);
		settle();
		chk("request cleared", {31'h0, periph_request}, 32'h0);
		periph_flags_1 <= 8'h40;
		wr(8'h08, 32'h40, 2'h0);
		settle();
		chk("active one", {24'h0, active_1}, 32'h40);
		chk("request group one", {31'h0, periph_request}, 32'h1);
		stop_test();
	end
endmodule : test_pfe_bank
